// ==== charger_i2c_pkg.sv ====
// Constants and types shared by the charger two-wire register port
`default_nettype none
package charger_i2c_pkg;

    // ------------------------------------------------------------
    // Bus addressing and register space
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h3b;
    localparam int REG_COUNT = 16;
    localparam logic [7:0] LAST_OFFSET = 8'h0f;
    localparam logic [7:0] FILL_BYTE = 8'hff;
    localparam logic [7:0] OFF_LIMIT_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE_CTRL = 8'h01;
    localparam logic [7:0] OFF_CHARGE_CURRENT = 8'h02;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_FAULT = 8'h09;
    localparam logic [7:0] OFF_FLAG = 8'h0e;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DISC_BIT = 7;
    localparam int STATSEL_LSB = 5;
    localparam int LIMIT_LSB = 0;
    localparam int SKIP_BIT = 7;
    localparam int KICK_BIT = 6;
    localparam int BOOST_BIT = 5;
    localparam int CHG_BIT = 4;
    localparam int SYSMIN_LSB = 1;
    localparam int LOWBAT_BIT = 0;

    // ------------------------------------------------------------
    // Power-on values, offset 0x0f down to 0x00
    // ------------------------------------------------------------
    localparam logic [REG_COUNT-1:0][7:0] RESET_VALUES = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h4c, 8'he6, 8'h9f, 8'h58, 8'h22, 8'ha2, 8'h1a, 8'h17};

    // ------------------------------------------------------------
    // Field decode values
    // ------------------------------------------------------------
    localparam logic [11:0] LIMIT_STEP_MA = 12'h064;
    localparam logic [4:0] LIMIT_TOP_CODE = 5'h1f;
    localparam logic [11:0] LIMIT_TOP_MA = 12'hed8;
    localparam logic [7:0][11:0] SYSMIN_MV = {
        12'he74, 12'he10, 12'hdac, 12'hd48, 12'hc80, 12'hbb8, 12'haf0, 12'ha28};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_ADDR  = 9'h002,
        ST_RXD   = 9'h004,
        ST_ACKW  = 9'h008,
        ST_ACK   = 9'h010,
        ST_ACKE  = 9'h020,
        ST_TXD   = 9'h040,
        ST_MACKW = 9'h080,
        ST_MACK  = 9'h100
    } port_state_t;

    typedef struct packed {
        logic [7:0] statusByte;
        logic [7:0] faultByte;
        logic [7:0] flagByte;
    } status_in_t;

    typedef struct packed {
        logic inputDisconnectEnable;
        logic [1:0] statusPinFunctionSelect;
        logic [4:0] inputCurrentLimitCode;
        logic [11:0] inputLimitMa;
        logic lightLoadPulseSkipDisable;
        logic watchdogKick;
        logic boostOutputEnable;
        logic chargeActive;
        logic [2:0] minimumSystemVoltageCode;
        logic [11:0] minSysMv;
        logic boostLowBatteryThresholdSelect;
    } ctrl_out_t;

endpackage
`default_nettype wire

// ==== charger_i2c_register_port.sv ====
// Two-wire target port and control registers of the charger controller
`timescale 1ns/1ps
`default_nettype none
module charger_i2c_register_port
    import charger_i2c_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    output logic sclOut,
    output logic sclOe_n,
    input wire logic chargeEnablePin_n,
    input wire logic srcDetectDone,
    input wire logic [4:0] srcDetectCode,
    input wire logic chargingNow,
    input wire logic customStat,
    input wire status_in_t statusIn,
    output logic statOut,
    output logic statOe_n,
    output ctrl_out_t ctrl
);

    // ------------------------------------------------------------
    // Link clock domain: sample the data line on each clock rise
    // ------------------------------------------------------------
    logic linkBit_q;
    logic linkBit_d;
    logic linkTgl_q;
    logic linkTgl_d;

    // The toggle marks a new bit; the bit itself holds for a full period
    always_comb begin
        linkBit_d = sdaIn;
        linkTgl_d = ~linkTgl_q;
    end

    // The link clock stops between frames, so nothing here needs a frame end
    always_ff @(posedge sclClk or negedge rst_b) begin
        if (!rst_b) begin
            linkBit_q <= 1'b1;
            linkTgl_q <= 1'b0;
        end else begin
            linkBit_q <= linkBit_d;
            linkTgl_q <= linkTgl_d;
        end
    end

    // ------------------------------------------------------------
    // Synchronisers into the system clock domain
    // ------------------------------------------------------------
    logic [2:0] sclSy_q;
    logic [2:0] sclSy_d;
    logic [2:0] sdaSy_q;
    logic [2:0] sdaSy_d;
    logic [2:0] cenSy_q;
    logic [2:0] cenSy_d;
    logic [2:0] tglSy_q;
    logic [2:0] tglSy_d;
    logic sclLvl_q;
    logic sclLvl_d;
    logic sdaLvl_q;
    logic sdaLvl_d;
    logic cenLvl_q;
    logic cenLvl_d;

    // A level counts once the second and third stages agree
    always_comb begin
        sclSy_d = {sclSy_q[1:0], sclClk};
        sdaSy_d = {sdaSy_q[1:0], sdaIn};
        cenSy_d = {cenSy_q[1:0], chargeEnablePin_n};
        tglSy_d = {tglSy_q[1:0], linkTgl_q};
        sclLvl_d = (sclSy_q[1] == sclSy_q[2]) ? sclSy_q[2] : sclLvl_q;
        sdaLvl_d = (sdaSy_q[1] == sdaSy_q[2]) ? sdaSy_q[2] : sdaLvl_q;
        cenLvl_d = (cenSy_q[1] == cenSy_q[2]) ? cenSy_q[2] : cenLvl_q;
    end

    // Idle bus reads high; the enable pin idles high (charging off)
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclSy_q <= 3'h7;
            sdaSy_q <= 3'h7;
            cenSy_q <= 3'h7;
            tglSy_q <= 3'h0;
            sclLvl_q <= 1'b1;
            sdaLvl_q <= 1'b1;
            cenLvl_q <= 1'b1;
        end else begin
            sclSy_q <= sclSy_d;
            sdaSy_q <= sdaSy_d;
            cenSy_q <= cenSy_d;
            tglSy_q <= tglSy_d;
            sclLvl_q <= sclLvl_d;
            sdaLvl_q <= sdaLvl_d;
            cenLvl_q <= cenLvl_d;
        end
    end

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    logic startEv;
    logic stopEv;
    logic sclFall;
    logic bitEv;

    // Start and stop are data edges seen while the clock stays high
    assign startEv = sclLvl_q & sclLvl_d & sdaLvl_q & ~sdaLvl_d;
    assign stopEv = sclLvl_q & sclLvl_d & ~sdaLvl_q & sdaLvl_d;
    assign sclFall = sclLvl_q & ~sclLvl_d;
    assign bitEv = tglSy_q[1] ^ tglSy_q[2];

    // ------------------------------------------------------------
    // Register file and read mux
    // ------------------------------------------------------------
    logic [REG_COUNT-1:0][7:0] regs_q;
    logic [REG_COUNT-1:0][7:0] regs_d;
    logic kick_q;
    logic kick_d;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;

    // Read value of one offset; burst marks a byte after the first of a read
    function automatic logic [7:0] readByte(input logic [7:0] ptr, input logic burst);
        logic [7:0] v;
        v = FILL_BYTE;
        if (ptr <= LAST_OFFSET) begin
            case (ptr)
                OFF_STATUS: v = statusIn.statusByte;
                OFF_FAULT: v = burst ? FILL_BYTE : statusIn.faultByte;
                OFF_FLAG: v = burst ? FILL_BYTE : statusIn.flagByte;
                default: v = regs_q[ptr[3:0]];
            endcase
        end
        return v;
    endfunction

    // Offsets the host may store into; status, fault and flag are read-only
    function automatic logic writable(input logic [7:0] ptr);
        return (ptr <= LAST_OFFSET) && (ptr != OFF_STATUS) &&
            (ptr != OFF_FAULT) && (ptr != OFF_FLAG);
    endfunction

    // Input limit code to milliamps
    function automatic logic [11:0] limitMa(input logic [4:0] code);
        logic [11:0] v;
        v = 12'(LIMIT_STEP_MA * (12'(code) + 12'h001));
        if (code == LIMIT_TOP_CODE) begin
            v = LIMIT_TOP_MA;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Port state machine
    // ------------------------------------------------------------
    port_state_t st_q;
    port_state_t st_d;
    logic [2:0] bitCnt_q;
    logic [2:0] bitCnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic rw_q;
    logic rw_d;
    logic first_q;
    logic first_d;
    logic drive_q;
    logic drive_d;
    logic [7:0] rxByte;

    // Drive is raised only after a seen clock fall, so data is stable while high; start, stop and idle release it
    always_comb begin
        st_d = st_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        first_d = first_q;
        drive_d = drive_q;
        wrEn = 1'b0;
        wrAddr = ptr_q;
        rxByte = {shift_q[6:0], linkBit_q};
        wrData = rxByte;
        if (stopEv) begin
            st_d = ST_IDLE;
            drive_d = 1'b0;
        end else if (startEv) begin
            st_d = ST_ADDR;
            bitCnt_d = 3'h0;
            drive_d = 1'b0;
        end else begin
            case (st_q)
                ST_ADDR, ST_RXD: begin
                    if (bitEv) begin
                        shift_d = rxByte;
                        bitCnt_d = bitCnt_q + 3'h1;
                        if (bitCnt_q == LAST_BIT) begin
                            st_d = ST_ACKW;
                            if (st_q == ST_ADDR) begin
                                rw_d = rxByte[0];
                                first_d = 1'b1;
                                tx_d = readByte(ptr_q, 1'b0);
                                if (rxByte[7:1] != DEV_ADDR) begin
                                    st_d = ST_IDLE;
                                end
                            end else if (first_q) begin
                                ptr_d = rxByte;
                                first_d = 1'b0;
                            end else begin
                                wrEn = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ST_ACKW: begin
                    if (sclFall) begin
                        drive_d = 1'b1;
                        st_d = ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (bitEv) begin
                        st_d = ST_ACKE;
                    end
                end
                ST_ACKE: begin
                    // After the ninth clock, release or put out the first data bit
                    if (sclFall) begin
                        bitCnt_d = 3'h0;
                        if (rw_q) begin
                            drive_d = ~tx_q[7];
                            st_d = ST_TXD;
                        end else begin
                            drive_d = 1'b0;
                            st_d = ST_RXD;
                        end
                    end
                end
                ST_TXD: begin
                    if (bitEv) begin
                        bitCnt_d = bitCnt_q + 3'h1;
                        if (bitCnt_q == LAST_BIT) begin
                            st_d = ST_MACKW;
                        end
                    end else if (sclFall) begin
                        tx_d = {tx_q[6:0], 1'b0};
                        drive_d = ~tx_q[6];
                    end
                end
                ST_MACKW: begin
                    if (sclFall) begin
                        drive_d = 1'b0;
                        st_d = ST_MACK;
                    end
                end
                ST_MACK: begin
                    if (bitEv) begin
                        if (!linkBit_q) begin
                            ptr_d = ptr_q + 8'h01;
                            tx_d = readByte(ptr_q + 8'h01, 1'b1);
                            st_d = ST_ACKE;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_IDLE: begin
                    drive_d = 1'b0;
                end
                default: begin
                    st_d = ST_IDLE;
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    // Pointer survives stop and start; only reset clears it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            first_q <= first_d;
            drive_q <= drive_d;
        end
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    // Order matters: a kick clears first, then a host write, then detection
    always_comb begin
        regs_d = regs_q;
        kick_d = 1'b0;
        if (regs_q[OFF_MODE_CTRL[3:0]][KICK_BIT]) begin
            regs_d[OFF_MODE_CTRL[3:0]][KICK_BIT] = 1'b0;
            kick_d = 1'b1;
        end
        if (wrEn && writable(wrAddr)) begin
            regs_d[wrAddr[3:0]] = wrData;
        end
        if (srcDetectDone) begin
            regs_d[OFF_LIMIT_CTRL[3:0]][LIMIT_LSB+:5] = srcDetectCode;
        end
    end

    // Power-on values for every writable register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regs_q <= RESET_VALUES;
            kick_q <= 1'b0;
        end else begin
            regs_q <= regs_d;
            kick_q <= kick_d;
        end
    end

    // ------------------------------------------------------------
    // Control outputs and pins
    // ------------------------------------------------------------
    ctrl_out_t ctrl_q;
    ctrl_out_t ctrl_d;
    logic statOe_n_q;
    logic statOe_n_d;
    logic [7:0] limReg;
    logic [7:0] modeReg;

    assign limReg = regs_q[OFF_LIMIT_CTRL[3:0]];
    assign modeReg = regs_q[OFF_MODE_CTRL[3:0]];

    // Decoded settings follow the registers one cycle later; the kick pulse two cycles later
    always_comb begin
        ctrl_d.inputDisconnectEnable = limReg[DISC_BIT];
        ctrl_d.statusPinFunctionSelect = limReg[STATSEL_LSB+:2];
        ctrl_d.inputCurrentLimitCode = limReg[LIMIT_LSB+:5];
        ctrl_d.inputLimitMa = limitMa(limReg[LIMIT_LSB+:5]);
        ctrl_d.lightLoadPulseSkipDisable = modeReg[SKIP_BIT];
        ctrl_d.watchdogKick = kick_q;
        ctrl_d.boostOutputEnable = modeReg[BOOST_BIT];
        ctrl_d.chargeActive = modeReg[CHG_BIT] & ~cenLvl_q & ~modeReg[BOOST_BIT];
        ctrl_d.minimumSystemVoltageCode = modeReg[SYSMIN_LSB+:3];
        ctrl_d.minSysMv = SYSMIN_MV[modeReg[SYSMIN_LSB+:3]];
        ctrl_d.boostLowBatteryThresholdSelect = modeReg[LOWBAT_BIT];
        case (limReg[STATSEL_LSB+:2])
            2'h0: statOe_n_d = ~chargingNow;
            2'h1: statOe_n_d = ~customStat;
            default: statOe_n_d = 1'b1;
        endcase
    end

    // Pins start released so a reset device never loads the bus
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= '0;
            statOe_n_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            statOe_n_q <= statOe_n_d;
        end
    end

    // Open-drain: the level driven is always low, only the enable moves
    assign sdaOut = 1'b0;
    assign sdaOe_n = ~drive_q;
    assign sclOut = 1'b0;
    assign sclOe_n = statOe_n_q | 1'b1;
    assign statOut = 1'b0;
    assign statOe_n = statOe_n_q;
    assign ctrl = ctrl_q;

endmodule // charger_i2c_register_port
`default_nettype wire

// ==== charger_i2c_register_port_sva.sv ====
// Concurrent checks on the outputs of the charger two-wire register port
`timescale 1ns/1ps
`default_nettype none
module charger_i2c_register_port_sva
    import charger_i2c_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclClk,
    input wire logic sdaOe_n,
    input wire logic sdaOut,
    input wire logic sclOut,
    input wire logic sclOe_n,
    input wire logic chargeEnablePin_n,
    input wire logic srcDetectDone,
    input wire logic [4:0] srcDetectCode,
    input wire logic statOe_n,
    input wire ctrl_out_t ctrl
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    // Decoded outputs still show zeros at the first edge after reset
    logic live_d;
    logic live_q;
    always_comb live_d = 1'b1;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) live_q <= 1'b0;
        else live_q <= live_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------
    a_clock_never_held: assert property (sclOe_n && !sclOut)
        else $error("clock pin driven by device");
    a_data_low_only: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
    // Drive moves one cycle after the seen fall, well inside the low phase
    a_drive_scl_low: assert property ($changed(sdaOe_n) |-> !sclClk)
        else $error("data drive moved while clock high");
    a_limit_decode: assert property (live_q |-> ctrl.inputLimitMa ==
        (ctrl.inputCurrentLimitCode == 5'h1f ? 12'hed8 :
        12'(12'h064 * (ctrl.inputCurrentLimitCode + 12'h001))))
        else $error("input limit decode wrong");
    a_sysmin_decode: assert property (live_q |->
        ctrl.minSysMv == SYSMIN_MV[ctrl.minimumSystemVoltageCode])
        else $error("minimum system voltage decode wrong");
    a_boost_wins: assert property (ctrl.boostOutputEnable |-> !ctrl.chargeActive)
        else $error("charging while boost enabled");
    a_pin_blocks: assert property (chargeEnablePin_n [*6] |-> !ctrl.chargeActive)
        else $error("charging with pin released");
    a_kick_pulse: assert property (ctrl.watchdogKick |=> !ctrl.watchdogKick)
        else $error("kick longer than one cycle");
    a_detect_load: assert property (srcDetectDone |->
        ##2 ctrl.inputCurrentLimitCode == $past(srcDetectCode, 2))
        else $error("detected code not loaded");
    a_stat_float: assert property (ctrl.statusPinFunctionSelect[1] &&
        $past(ctrl.statusPinFunctionSelect[1]) |-> statOe_n)
        else $error("status pin not floating");
    c_detect: cover property (srcDetectDone);
    c_kick: cover property (ctrl.watchdogKick);
    c_boost: cover property (ctrl.boostOutputEnable);
endmodule // charger_i2c_register_port_sva

bind charger_i2c_register_port charger_i2c_register_port_sva u_charger_i2c_register_port_sva (
    .clk(clk), .rst_b(rst_b), .sdaOut(sdaOut), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .chargeEnablePin_n(chargeEnablePin_n), .srcDetectDone(srcDetectDone),
    .srcDetectCode(srcDetectCode), .statOe_n(statOe_n), .ctrl(ctrl),
    .sclClk(sclClk), .sdaOe_n(sdaOe_n));
`default_nettype wire

// ==== i2c_host_model.sv ====
// Two-wire bus master model: makes the bus clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
    parameter int QTR_NS = 850
) (
    input wire logic sda,
    output logic sclClk,
    output logic hostPull,
    output logic [8:0] rxData,
    output logic rxStrobe
);
    // Bus free: both lines released, clock stands still between frames
    initial begin
        sclClk = 1'b1;
        hostPull = 1'b0;
        rxData = 9'h000;
        rxStrobe = 1'b0;
    end
    // Data falls while clock is high
    task automatic start_cond();
        hostPull = 1'b1;
        #QTR_NS sclClk = 1'b0;
        #QTR_NS;
    endtask
    // Release data in the low phase, raise clock, then pull data again
    task automatic restart_cond();
        hostPull = 1'b0;
        #QTR_NS sclClk = 1'b1;
        #QTR_NS hostPull = 1'b1;
        #QTR_NS sclClk = 1'b0;
        #QTR_NS;
    endtask
    // Data rises while clock is high
    task automatic stop_cond();
        hostPull = 1'b1;
        #QTR_NS sclClk = 1'b1;
        #QTR_NS hostPull = 1'b0;
        #QTR_NS;
    endtask
    // Eight bits MSB first then the ninth; a one bit releases the line
    // Data changes a full quarter after the fall to clear synchroniser skew
    task automatic byte9(input logic [8:0] tx);
        for (int i = 8; i >= 0; i--) begin
            hostPull = !tx[i];
            #QTR_NS sclClk = 1'b1;
            #(QTR_NS / 2) rxData[i] = sda;
            #(QTR_NS / 2) sclClk = 1'b0;
            #QTR_NS;
        end
        rxStrobe = 1'b1;
        #1 rxStrobe = 1'b0;
    endtask
endmodule // i2c_host_model
`default_nettype wire

// ==== tb_charger_i2c_register_port.sv ====
// Self-checking bench for the charger two-wire register port
`timescale 1ns/1ps
`default_nettype none
module tb_charger_i2c_register_port;
    import charger_i2c_pkg::*;
    // ------------------------------------------------------------
    // Signals, wire resolution and instances
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sclClk, hostPull, rxStrobe, sdaOut, sdaOe_n, sclOut, sclOe_n, statOut, statOe_n;
    logic [8:0] rxData;
    logic chargeEnablePin_n = 1'b0;
    logic srcDetectDone = 1'b0;
    logic [4:0] srcDetectCode = 5'h00;
    logic chargingNow = 1'b1;
    logic customStat = 1'b0;
    status_in_t statusIn = '0;
    ctrl_out_t ctrl;
    logic [8:0] expQ[$];
    logic [31:0] rnd;
    int seed = 32'h46c6;
    int fail_count = 0;
    int checked = 0;
    // Pull-up wins unless someone pulls low
    wire sda = (sdaOe_n == 1'b0 || hostPull) ? 1'b0 : 1'b1;
    initial forever #12.5 clk = ~clk;
    charger_i2c_register_port u_charger_i2c_register_port (.clk(clk), .rst_b(rst_b),
        .sclClk(sclClk), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .sclOut(sclOut),
        .sclOe_n(sclOe_n), .chargeEnablePin_n(chargeEnablePin_n),
        .srcDetectDone(srcDetectDone), .srcDetectCode(srcDetectCode),
        .chargingNow(chargingNow), .customStat(customStat), .statusIn(statusIn),
        .statOut(statOut), .statOe_n(statOe_n), .ctrl(ctrl));
    i2c_host_model u_i2c_host_model (.sda(sda), .sclClk(sclClk), .hostPull(hostPull),
        .rxData(rxData), .rxStrobe(rxStrobe));
    // ------------------------------------------------------------
    // Compare, transfer and closing tasks
    // ------------------------------------------------------------
    task automatic check_bus(input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD bus byte exp %h got %h", exp, got);
        end
    endtask
    task automatic check_val(input string name, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Note what the wire must show, then clock the byte out
    task automatic xb(input logic [8:0] tx, input logic [8:0] ex);
        expQ.push_back(ex);
        u_i2c_host_model.byte9(tx);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [31:0] dat, input int n);
        u_i2c_host_model.start_cond();
        xb({DEV_ADDR, 2'b01}, {DEV_ADDR, 2'b00});
        xb({ptr, 1'b1}, {ptr, 1'b0});
        for (int i = 0; i < n; i++) xb({dat[31-8*i -: 8], 1'b1}, {dat[31-8*i -: 8], 1'b0});
        u_i2c_host_model.stop_cond();
    endtask
    task automatic rd(input logic [7:0] ptr, input logic [31:0] exp, input int n, input bit setPtr);
        u_i2c_host_model.start_cond();
        if (setPtr) begin
            xb({DEV_ADDR, 2'b01}, {DEV_ADDR, 2'b00});
            xb({ptr, 1'b1}, {ptr, 1'b0});
            u_i2c_host_model.restart_cond();
        end
        xb({DEV_ADDR, 2'b11}, {DEV_ADDR, 2'b10});
        for (int i = 0; i < n; i++) xb({8'hff, i == n - 1}, {exp[31-8*i -: 8], i == n - 1});
        u_i2c_host_model.stop_cond();
    endtask
    // Each byte seen on the wire is matched against the oldest note
    always @(posedge rxStrobe) begin
        if (expQ.size() == 0) begin
            fail_count++;
            $display("BAD bus byte exp none got %h", rxData);
        end else check_bus(expQ.pop_front(), rxData);
    end
    // Hang guard, about 1.6 times the run length
    initial begin
        #2400000;
        fail_count++;
        $display("BAD run time exp done got timeout");
        finish_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(5);
        rst_b = 1'b1;
        tick(6);
        check_val("limit mA", 12'h960, ctrl.inputLimitMa);
        check_val("sysmin mV", 12'hdac, ctrl.minSysMv);
        check_val("charging", 12'h001, {11'h0, ctrl.chargeActive});
        check_val("stat pin", 12'h000, {11'h0, statOe_n});
        rd(8'h00, 32'h171aa222, 4, 1'b1);
        // Foreign address: no ack, and the next byte is left alone too
        u_i2c_host_model.start_cond();
        xb({7'h3a, 2'b01}, {7'h3a, 2'b01});
        xb({8'h00, 1'b1}, {8'h00, 1'b1});
        u_i2c_host_model.stop_cond();
        wr(8'h01, 32'h30000000, 1);
        tick(4);
        check_val("boost", 12'h001, {11'h0, ctrl.boostOutputEnable});
        check_val("charging", 12'h000, {11'h0, ctrl.chargeActive});
        wr(8'h01, 32'hdf000000, 1);
        tick(1);
        chargeEnablePin_n = 1'b1;
        tick(8);
        check_val("charging", 12'h000, {11'h0, ctrl.chargeActive});
        check_val("sysmin mV", 12'he74, ctrl.minSysMv);
        check_val("mode bits", 12'h003, {10'h0, ctrl.lightLoadPulseSkipDisable,
            ctrl.boostLowBatteryThresholdSelect});
        chargeEnablePin_n = 1'b0;
        tick(8);
        check_val("charging", 12'h001, {11'h0, ctrl.chargeActive});
        rd(8'h01, 32'h9f000000, 1, 1'b1);
        rnd = $random(seed);
        wr(8'h0a, rnd, 4);
        rd(8'h0a, rnd, 4, 1'b1);
        wr(8'h0c, 32'h0, 0);
        rd(8'h00, {rnd[15:8], 24'h0}, 1, 1'b0);
        tick(1);
        statusIn = rnd[23:0];
        rd(8'h0f, 32'h00ff0000, 2, 1'b1);
        rd(8'h08, {statusIn.statusByte, 8'hff, 16'h0}, 2, 1'b1);
        rd(8'h09, {statusIn.faultByte, 24'h0}, 1, 1'b1);
        tick(1);
        rnd = $random(seed);
        for (int k = 0; k < 2; k++) begin
            srcDetectCode = k ? 5'h1f : rnd[4:0];
            srcDetectDone = 1'b1;
            tick(1);
            srcDetectDone = 1'b0;
            tick(3);
            check_val("limit code", {7'h0, srcDetectCode}, {7'h0, ctrl.inputCurrentLimitCode});
            check_val("limit mA", srcDetectCode == 5'h1f ? 12'hed8 :
                12'h064 * (srcDetectCode + 12'h001), ctrl.inputLimitMa);
        end
        rd(8'h00, 32'h1f000000, 1, 1'b1);
        wr(8'h00, 32'hc0000000, 1);
        tick(4);
        check_val("stat float", 12'h001, {11'h0, statOe_n});
        check_val("disconnect", 12'h001, {11'h0, ctrl.inputDisconnectEnable});
        customStat = 1'b1;
        wr(8'h00, 32'h20000000, 1);
        tick(4);
        check_val("stat custom", 12'h000, {11'h0, statOe_n});
        if (expQ.size() != 0) begin
            fail_count++;
            $display("BAD bus queue exp 0 got %0d", expQ.size());
        end
        finish_test();
    end
endmodule // tb_charger_i2c_register_port
`default_nettype wire
